// ### shared/ept_pkg.sv
// constants, register map and field layout of the eight bit prescaled timer
// assumes a 125 MHz apb clock that also serves as the internal frequency
package ept_pkg;

	// register indices; the byte address on apb is four times the index
	localparam logic [9:0] IDX_PRESCALER_COUNT        = 10'h0D2; // prescaler state
	localparam logic [9:0] IDX_TIMER_COUNT            = 10'h0D3; // count value
	localparam logic [9:0] IDX_TIMER_STATUS_CONTROL   = 10'h0D4; // status and control

	// values after reset and terminal counts
	localparam logic [6:0] PRESCALER_RESET            = 7'h7F;   // also the reload value
	localparam logic [7:0] COUNT_RESET                = 8'hFF;   // also the underflow value
	localparam logic [7:0] COUNT_ZERO                 = 8'h00;   // terminal count
	localparam logic [6:0] PRESCALER_ZERO             = 7'h00;   // prescaler terminal count

	// field positions in timer_status_control
	localparam int         POS_ZERO_FLAG              = 7;
	localparam int         POS_IRQ_ENABLE             = 6;
	localparam int         POS_PIN_DIRECTION_OUT      = 5;
	localparam int         POS_PIN_LEVEL_MODE         = 4;
	localparam int         POS_PRESCALER_RUN          = 3;

	// internal frequency divided by twelve
	localparam int         INTERNAL_DIVIDE            = 12;
	localparam logic [3:0] DIV12_LAST                 = 4'(INTERNAL_DIVIDE - 1);
	localparam logic [3:0] DIV12_RESET                = 4'h0;

	// writable control fields of timer_status_control, bits 6 to 0
	typedef struct packed {
		logic       irq_enable;        // bit 6
		logic       pin_direction_out; // bit 5
		logic       pin_level_mode;    // bit 4
		logic       prescaler_run;     // bit 3
		logic [2:0] divider_select;    // bits 2 to 0
	} ept_ctl_t;

	localparam ept_ctl_t   CTL_RESET                  = 7'h00;

	// operating modes decoded from direction and level bits
	typedef enum logic [1:0] {
		MODE_EVENT,
		MODE_GATED,
		MODE_OUT_LOW,
		MODE_OUT_HIGH
	} ept_mode_t;

endpackage

// ### hw/ept_timer.sv
// eight bit down counter behind a seven bit prescaler with apb register access
// assumes an apb master on pclk and a timer pin from outside the clock domain
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - count value is always an 8-bit downcounter
// - decrement to zero sets zero_flag
// - underflow passes 00h to FFh, flag unchanged
// - interrupt when irq_enable and zero_flag both set
// - interrupt request also serves as wake-up
// - writing 00h count or flag bit sets flag
// - count writes load a new period anytime
// - count write beats a coincident decrement
// - mode decoded from direction and level bits
// - gated mode: divided tick only while pin high
// - event mode: pin rising edge clocks prescaler
// - output mode: divided tick clocks prescaler
// - flag rise latches level, drives pin
// - direction bit makes the pin push-pull output
// - stop freezes timer except event counting
// - run low holds prescaler 7Fh, no counting
// - divider_select picks tap, divide by 2^n
// - prescaler reads in bits 6:0, bit 7 zero
// - prescaler reloads 7Fh after reaching zero
// - prescaler writable while running, 0 to 7Fh
module ept_timer
(
	input  wire logic        pclk,           // apb clock, also the internal frequency
	input  wire logic        presetn,        // asynchronous reset, active low
	input  wire logic        psel,           // apb select
	input  wire logic        penable,        // apb access phase
	input  wire logic        pwrite,         // apb direction, high for write
	input  wire logic [11:0] paddr,          // apb byte address
	input  wire logic [31:0] pwdata,         // apb write data
	output logic      [31:0] prdata,         // apb read data
	output logic             pready,         // apb ready
	output logic             pslverr,        // apb error for unmapped address
	input  wire logic        stop_mode,      // core is in the stop low-power state
	input  wire logic        counter_pin_i,  // level seen on the timer pin
	output logic             counter_pin_o,  // level driven on the timer pin
	output logic             counter_pin_oe, // high while the pin is driven
	output logic             timer_irq       // interrupt and wake-up request
);

	// pin synchroniser and edge memory
	logic             pin_meta_q;     // first stage, read only by the second
	logic             pin_sync_q;     // second stage
	logic             pin_prev_q;     // previous synchronised level
	logic             pin_rise;       // one-cycle rising edge enable

	// divide-by-twelve tick
	logic [3:0]       div12_q;        // tick counter
	logic [3:0]       div12_d;
	logic             tick12;         // one-cycle enable every twelve clocks

	// timer state
	logic [6:0]       psc_q;          // prescaler
	logic [6:0]       psc_d;
	logic [7:0]       count_q;        // count value
	logic [7:0]       count_d;
	logic             zero_flag_q;    // sticky zero flag
	logic             zero_flag_d;
	logic             level_latch_q;  // level latched on flag rise
	logic             level_latch_d;
	ept_pkg::ept_ctl_t ctl_q;         // control fields
	ept_pkg::ept_ctl_t ctl_d;
	logic             irq_d;
	logic             flag_set;       // some cause sets zero_flag this cycle

	// bus state
	logic             pready_d;
	logic             pslverr_d;
	logic [31:0]      prdata_d;

	// decode helpers
	ept_pkg::ept_mode_t mode;         // current operating mode
	logic             psc_en;         // prescaler clock enable
	logic             frozen;         // stop freezes this mode
	logic             cnt_step;       // prescaler tap fires
	logic [6:0]       tap_mask;       // low prescaler bits for the tap
	logic             access;         // apb access completes this edge
	logic             hit_psc;        // address decodes
	logic             hit_cnt;
	logic             hit_tsc;
	logic             wr_psc;         // completed writes
	logic             wr_cnt;
	logic             wr_tsc;

	// two-flop synchroniser, then a third flop for edge detection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			pin_prev_q <= 1'b0;
		end
		else
		begin
			pin_meta_q <= counter_pin_i;
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	// rising edge of the synchronised pin
	assign pin_rise = pin_sync_q & ~pin_prev_q;

	// next value of the divide-by-twelve counter
	always_comb
	begin
		tick12 = (div12_q == ept_pkg::DIV12_LAST);
		if (tick12)
			div12_d = ept_pkg::DIV12_RESET;
		else
			div12_d = div12_q + 4'h1;
	end

	// register the divider
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div12_q <= ept_pkg::DIV12_RESET;
		else
			div12_q <= div12_d;
	end

	// mode decode and prescaler clock source
	always_comb
	begin
		mode   = ept_pkg::ept_mode_t'({ctl_q.pin_direction_out, ctl_q.pin_level_mode});
		psc_en = 1'b0;
		frozen = 1'b0;
		unique case (mode)
			ept_pkg::MODE_EVENT:
			begin
				psc_en = pin_rise;
				frozen = 1'b0;
			end
			ept_pkg::MODE_GATED:
			begin
				psc_en = tick12 & pin_sync_q;
				frozen = stop_mode;
			end
			ept_pkg::MODE_OUT_LOW, ept_pkg::MODE_OUT_HIGH:
			begin
				psc_en = tick12;
				frozen = stop_mode;
			end
		endcase
		// tap: count steps when the low n prescaler bits are all zero
		tap_mask = 7'((8'h01 << ctl_q.divider_select) - 8'h01);
		cnt_step = ctl_q.prescaler_run & psc_en & ~frozen
			& ((psc_q & tap_mask) == ept_pkg::PRESCALER_ZERO);
	end

	// apb decode; registers sit at four times their index
	always_comb
	begin
		access  = psel & penable & pready;
		hit_psc = (paddr[11:2] == ept_pkg::IDX_PRESCALER_COUNT);
		hit_cnt = (paddr[11:2] == ept_pkg::IDX_TIMER_COUNT);
		hit_tsc = (paddr[11:2] == ept_pkg::IDX_TIMER_STATUS_CONTROL);
		wr_psc  = access & pwrite & hit_psc;
		wr_cnt  = access & pwrite & hit_cnt;
		wr_tsc  = access & pwrite & hit_tsc;
	end

	// next timer state
	always_comb
	begin
		psc_d         = psc_q;
		count_d       = count_q;
		zero_flag_d   = zero_flag_q;
		ctl_d         = ctl_q;
		level_latch_d = level_latch_q;
		flag_set      = 1'b0;
		// prescaler
		if (!ctl_q.prescaler_run)
			psc_d = ept_pkg::PRESCALER_RESET;
		else if (wr_psc)
			psc_d = pwdata[6:0];
		else if (psc_en && !frozen)
		begin
			if (psc_q == ept_pkg::PRESCALER_ZERO)
				psc_d = ept_pkg::PRESCALER_RESET;
			else
				psc_d = psc_q - 7'h01;
		end
		// counter; a write wins over a coincident decrement
		if (wr_cnt)
		begin
			count_d = pwdata[7:0];
			if (pwdata[7:0] == ept_pkg::COUNT_ZERO)
				flag_set = 1'b1;
		end
		else if (cnt_step)
		begin
			if (count_q == ept_pkg::COUNT_ZERO)
				count_d = ept_pkg::COUNT_RESET;
			else
			begin
				count_d = count_q - 8'h01;
				if (count_q == 8'h01)
					flag_set = 1'b1;
			end
		end
		// control writes; software may clear the flag but a set wins
		if (wr_tsc)
		begin
			ctl_d = ept_pkg::ept_ctl_t'(pwdata[6:0]);
			if (pwdata[ept_pkg::POS_ZERO_FLAG])
				flag_set = 1'b1;
			else
				zero_flag_d = 1'b0;
		end
		// a set beats a coincident clear, even while the flag already stands
		if (flag_set)
			zero_flag_d = 1'b1;
		// latch the level on every rise of the flag
		if (zero_flag_d && !zero_flag_q)
			level_latch_d = ctl_d.pin_level_mode;
		// request while flag and enable are both set, not gated by stop
		irq_d = zero_flag_d & ctl_d.irq_enable;
	end

	// register the timer state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			psc_q          <= ept_pkg::PRESCALER_RESET;
			count_q        <= ept_pkg::COUNT_RESET;
			zero_flag_q    <= 1'b0;
			ctl_q          <= ept_pkg::CTL_RESET;
			level_latch_q  <= 1'b0;
			timer_irq      <= 1'b0;
			counter_pin_o  <= 1'b0;
			counter_pin_oe <= 1'b0;
		end
		else
		begin
			psc_q          <= psc_d;
			count_q        <= count_d;
			zero_flag_q    <= zero_flag_d;
			ctl_q          <= ctl_d;
			level_latch_q  <= level_latch_d;
			timer_irq      <= irq_d;
			counter_pin_o  <= level_latch_d;
			counter_pin_oe <= ctl_d.pin_direction_out;
		end
	end

	// bus answer: one wait state, data and error with ready
	always_comb
	begin
		pready_d  = psel & penable & ~pready;
		pslverr_d = 1'b0;
		prdata_d  = 32'h0000_0000;
		if (pready_d)
		begin
			if (hit_psc)
				prdata_d = {25'h0000000, psc_q};
			else if (hit_cnt)
				prdata_d = {24'h000000, count_q};
			else if (hit_tsc)
				prdata_d = {24'h000000, zero_flag_q, ctl_q};
			else
				pslverr_d = 1'b1;                           // unmapped
		end
	end

	// register the bus answer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= pready_d;
			pslverr <= pslverr_d;
			prdata  <= prdata_d;
		end
	end

endmodule // ept_timer

`default_nettype wire

// ### test/ept_timer_props.sv
// port checks of the prescaled timer
// assumes it is bound onto ept_timer
`timescale 1ns/100ps
`default_nettype none
module ept_timer_props
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        stop_mode,
	input wire logic        counter_pin_i,
	input wire logic        counter_pin_o,
	input wire logic        counter_pin_oe,
	input wire logic        timer_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic hit;    // address is one of the three registers
	wire logic wr_ctl; // status control write completes
	assign hit = paddr[11:2] inside {ept_pkg::IDX_PRESCALER_COUNT,
		ept_pkg::IDX_TIMER_COUNT, ept_pkg::IDX_TIMER_STATUS_CONTROL};
	assign wr_ctl = psel && penable && pready && pwrite
		&& paddr[11:2] == ept_pkg::IDX_TIMER_STATUS_CONTROL;
	ready_wait_a:
	assert property (psel && penable && !pready |=> pready) else $error("late ready");
	ready_pulse_a:
	assert property (pready |=> !pready) else $error("ready too long");
	upper_zero_a:
	assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper data set");
	error_decode_a:
	assert property (pready |-> pslverr == !hit) else $error("bad error response");
	irq_mask_a:
	assert property (wr_ctl && !pwdata[6] |=> !timer_irq) else $error("irq unmasked");
	flag_set_a:
	assert property (wr_ctl && pwdata[7] && pwdata[6] |=> timer_irq) else $error("no flag");
	pin_dir_a:
	assert property (wr_ctl |=> counter_pin_oe == $past(pwdata[5])) else $error("bad oe");
	irq_hold_a:
	assert property ($fell(timer_irq) |-> $past(wr_ctl)) else $error("irq self cleared");
	oe_hold_a:
	assert property ($changed(counter_pin_oe) |-> $past(wr_ctl)) else $error("oe moved");
	cover property (wr_ctl && pwdata[7]);
	cover property ($rose(timer_irq) && counter_pin_oe);
	cover property (pslverr);
endmodule // ept_timer_props
bind ept_timer ept_timer_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .stop_mode(stop_mode), .counter_pin_i(counter_pin_i),
	.counter_pin_o(counter_pin_o), .counter_pin_oe(counter_pin_oe), .timer_irq(timer_irq));
`default_nettype wire

// ### test/ept_pin_model.sv
// far side of the timer pin: outside source and the wire
// assumes its tasks are called right after a rising pclk edge
`timescale 1ns/100ps
`default_nettype none
module ept_pin_model
(
	input  wire logic pclk,
	input  wire logic pin_o,
	input  wire logic pin_oe,
	output logic      pin_i
);
	logic ext_q = 1'b0; // level the outside source drives
	// the timer wins the wire while it drives
	assign pin_i = pin_oe ? pin_o : ext_q;
	// hold a level for gating
	task automatic level(input logic v);
		ext_q <= v;
	endtask
	// rising edges for event counting, 4 cycles per level
	task automatic pulses(input int n);
		repeat (n)
		begin
			ext_q <= 1'b1;
			repeat (4) @(posedge pclk);
			ext_q <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask
endmodule // ept_pin_model
`default_nettype wire

// ### test/ept_timer_tb_top.sv
// self-checking bench for the prescaled timer over apb
// assumes package, pin model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module ept_timer_tb_top;
	localparam logic [9:0] PS = ept_pkg::IDX_PRESCALER_COUNT;
	localparam logic [9:0] TC = ept_pkg::IDX_TIMER_COUNT;
	localparam logic [9:0] SC = ept_pkg::IDX_TIMER_STATUS_CONTROL;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        stop_mode = 1'b0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, er, pin_i, pin_o, pin_oe, irq;
	int          fail_count = 0;
	int          cmp_count = 0;
	always #4 pclk = ~pclk;
	ept_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stop_mode(stop_mode), .counter_pin_i(pin_i),
		.counter_pin_o(pin_o), .counter_pin_oe(pin_oe), .timer_irq(irq));
	ept_pin_model u_pin (.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));
	// count and report one comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until ready
	task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {ix, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// request must come between lo and hi cycles
	task automatic wirq(input int lo, input int hi);
		int n;
		n = 0;
		while (irq !== 1'b1 && n <= hi)
		begin
			@(posedge pclk);
			n++;
		end
		chk(n >= lo && n <= hi, 32'h1);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		results();
	end
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, PS, 8'h00);
		chk(rd, 32'h7F);
		apb(0, TC, 8'h00);
		chk(rd, 32'hFF);
		apb(0, 10'h0D5, 8'h00);
		chk(er, 32'h1);
		$display("reset values done");
		apb(1, SC, 8'hC0);
		chk(irq, 32'h1);
		apb(1, SC, 8'h40);
		chk(irq, 32'h0);
		apb(1, TC, 8'h00);
		chk(irq, 32'h1);
		apb(0, SC, 8'h00);
		chk(rd, 32'hC0);
		apb(1, SC, 8'h80);
		chk(irq, 32'h0);
		apb(0, SC, 8'h00);
		chk(rd, 32'h80);
		$display("flag test done");
		apb(1, PS, 8'h10);
		apb(0, PS, 8'h00);
		chk(rd, 32'h7F);
		apb(1, SC, 8'h08);
		apb(1, PS, 8'h15);
		apb(0, PS, 8'h00);
		chk(rd, 32'h15);
		apb(1, SC, 8'h00);
		apb(0, PS, 8'h00);
		chk(rd, 32'h7F);
		$display("prescaler test done");
		for (int d = 0; d < 3; d++)
		begin
			apb(1, TC, 8'h02);
			apb(1, SC, {3'b011, ~d[0], 1'b1, d[2:0]});
			wirq((24 << d) - 12, (24 << d) + 1);
			chk(pin_o, {31'h0, ~d[0]});
			chk(pin_oe, 32'h1);
			apb(1, SC, {3'b011, ~d[0], 1'b0, d[2:0]});
		end
		$display("output mode done");
		apb(1, TC, 8'h02);
		apb(1, SC, 8'h48);
		chk(pin_oe, 32'h0);
		stop_mode <= 1'b1;
		u_pin.pulses(1);
		chk(irq, 32'h0);
		u_pin.pulses(1);
		wirq(0, 4);
		u_pin.pulses(1);
		apb(0, TC, 8'h00);
		chk(rd, 32'hFF);
		$display("event mode done");
		for (int k = 0; k < 2; k++)
		begin
			apb(1, SC, 8'h00);
			apb(1, TC, 8'h01);
			stop_mode <= k[0];
			apb(1, SC, k ? 8'h68 : 8'h58);
			repeat (60) @(posedge pclk);
			chk(irq, 32'h0);
			stop_mode <= 1'b0;
			u_pin.level(1'b1);
			wirq(0, 40);
			u_pin.level(1'b0);
		end
		$display("hold test done");
		results();
	end
endmodule // ept_timer_tb_top
`default_nettype wire
